// [tmr_consts.svh]
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
// Waveform modes
`define TMR_WGM_NORMAL 2'h0
`define TMR_WGM_PCPWM  2'h1
`define TMR_WGM_CTC    2'h2
`define TMR_WGM_FPWM   2'h3
// Compare output modes
`define TMR_COM_OFF    2'h0
`define TMR_COM_TOGGLE 2'h1
`define TMR_COM_CLEAR  2'h2
`define TMR_COM_SET    2'h3
// Counter extremes, clock select stop code and reset values
`define TMR_MAX        8'hff
`define TMR_BOTTOM     8'h00
`define TMR_CS_STOP    3'h0
`define TMR_CNT_RST    8'h00
`define TMR_OC_RST     1'h0
`endif

// [tmr_pkg.sv]
package tmr_pkg;
    typedef logic [1:0] tmr_wgm_t;
    typedef logic [1:0] tmr_com_t;
    typedef logic [7:0] tmr_byte_t;
endpackage

// [tmr_tick_sel.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.svh"
// Picks the tick enable named by the clock select code
module tmr_tick_sel (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic [2:0] clock_select,
    input  wire logic [7:1] tick_sources,
    output logic            timer_tick
);
    typedef struct packed {
        logic tick;
    } tmr_sel_state_t;

    tmr_sel_state_t s_q;
    tmr_sel_state_t s_d;

    // Code zero chooses no source, so the counter stands still
    always_comb begin
        s_d = s_q;
        if (clock_select == `TMR_CS_STOP) begin
            s_d.tick = 1'b0;
        end else begin
            s_d.tick = tick_sources[clock_select];
        end
    end

    // Registered so the tick is a clean single-cycle enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign timer_tick = s_q.tick;
endmodule
`default_nettype wire

// [tmr_core.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.svh"
module tmr_core
    import tmr_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            ce,
    input  wire logic [2:0]      clock_select,
    input  wire logic [7:1]      tick_sources,
    input  wire tmr_pkg::tmr_wgm_t waveform_mode,
    input  wire tmr_pkg::tmr_com_t compare_output_mode,
    input  wire logic            count_wr,
    input  wire tmr_pkg::tmr_byte_t count_wdata,
    input  wire logic            compare_wr,
    input  wire tmr_pkg::tmr_byte_t compare_wdata,
    input  wire logic            force_compare_strobe,
    input  wire logic            compare_flag_wr_one,
    input  wire logic            overflow_flag_wr_one,
    input  wire logic            compare_irq_enable,
    input  wire logic            overflow_irq_enable,
    input  wire logic            global_irq_enable,
    input  wire logic            compare_irq_ack,
    input  wire logic            overflow_irq_ack,
    input  wire logic            port_value,
    input  wire logic            output_pin_direction,
    output tmr_pkg::tmr_byte_t   count_value,
    output tmr_pkg::tmr_byte_t   compare_value,
    output logic                 compare_flag,
    output logic                 overflow_flag,
    output logic                 compare_irq,
    output logic                 overflow_irq,
    output logic                 compare_output,
    output logic                 pin_out,
    output logic                 pin_oe
);
    import tmr_pkg::*;

    typedef struct packed {
        tmr_byte_t cnt;
        tmr_byte_t ocr;
        tmr_byte_t ocr_buf;
        logic      down;
        logic      blk;
        logic      ocf;
        logic      tov;
        logic      oc;
        logic      match_seen;
    } tmr_state_t;

    tmr_state_t s_q;
    tmr_state_t s_d;
    logic       timer_tick;
    logic       match;
    logic       pwm;
    logic       at_top;
    logic       at_bottom;

    // Tick enables come from the prescaler; code zero stops counting
    tmr_tick_sel u_tick (
        .clk          (clk),
        .rst_n        (rst_n),
        .ce           (ce),
        .clock_select (clock_select),
        .tick_sources (tick_sources),
        .timer_tick   (timer_tick)
    );

    function automatic logic is_pwm(input tmr_wgm_t m);
        is_pwm = (m == `TMR_WGM_PCPWM) || (m == `TMR_WGM_FPWM);
    endfunction

    // Mode decode and comparator
    assign pwm       = is_pwm(waveform_mode);
    assign match     = (s_q.cnt == s_q.ocr);
    assign at_top    = (s_q.cnt == `TMR_MAX);
    assign at_bottom = (s_q.cnt == `TMR_BOTTOM);

    // Counter, compare, flags and waveform next state
    always_comb begin
        s_d = s_q;
        if (timer_tick) begin
            // Matches are blocked for the tick after a counter write
            s_d.blk = 1'b0;
            unique case (waveform_mode)
                `TMR_WGM_NORMAL: begin
                    s_d.cnt = s_q.cnt + 8'h01;
                    s_d.down = 1'b0;
                end
                `TMR_WGM_CTC: begin
                    s_d.down = 1'b0;
                    if (match && !s_q.blk) begin
                        s_d.cnt = `TMR_BOTTOM;
                    end else begin
                        s_d.cnt = s_q.cnt + 8'h01;
                    end
                end
                `TMR_WGM_FPWM: begin
                    s_d.down = 1'b0;
                    s_d.cnt = s_q.cnt + 8'h01;
                end
                `TMR_WGM_PCPWM: begin
                    // Direction turns at max and at bottom
                    if (!s_q.down && at_top) begin
                        s_d.down = 1'b1;
                        s_d.cnt = s_q.cnt - 8'h01;
                    end else if (s_q.down && at_bottom) begin
                        s_d.down = 1'b0;
                        s_d.cnt = s_q.cnt + 8'h01;
                    end else if (s_q.down) begin
                        s_d.cnt = s_q.cnt - 8'h01;
                    end else begin
                        s_d.cnt = s_q.cnt + 8'h01;
                    end
                end
            endcase
            // Overflow: zero reached from max, or bottom in phase correct
            if (waveform_mode == `TMR_WGM_PCPWM) begin
                if (s_q.down && s_q.cnt == 8'h01) begin
                    s_d.tov = 1'b1;
                end
            end else if (at_top) begin
                s_d.tov = 1'b1;
            end
            // Flag rises on the tick that follows the match
            if (match && !s_q.blk) begin
                s_d.ocf = 1'b1;
            end
            s_d.match_seen = match && !s_q.blk;
            // Output action at match; mode zero leaves it alone
            if (match && !s_q.blk) begin
                unique case (compare_output_mode)
                    `TMR_COM_OFF: s_d.oc = s_q.oc;
                    `TMR_COM_TOGGLE: begin
                        if (!pwm) begin
                            s_d.oc = ~s_q.oc;
                        end
                    end
                    `TMR_COM_CLEAR: begin
                        if (waveform_mode == `TMR_WGM_PCPWM) begin
                            s_d.oc = s_q.down;
                        end else begin
                            s_d.oc = 1'b0;
                        end
                    end
                    `TMR_COM_SET: begin
                        if (waveform_mode == `TMR_WGM_PCPWM) begin
                            s_d.oc = ~s_q.down;
                        end else begin
                            s_d.oc = 1'b1;
                        end
                    end
                endcase
            end else if (waveform_mode == `TMR_WGM_FPWM && at_top) begin
                // Fast PWM restores the level as the count wraps
                if (compare_output_mode == `TMR_COM_CLEAR) begin
                    s_d.oc = 1'b1;
                end else if (compare_output_mode == `TMR_COM_SET) begin
                    s_d.oc = 1'b0;
                end
            end
            // Buffered compare loads at top (fast) or max (phase correct)
            if (pwm && at_top) begin
                s_d.ocr = s_q.ocr_buf;
            end
        end
        // Forced match moves only the output, in non-PWM modes
        if (force_compare_strobe && !pwm) begin
            unique case (compare_output_mode)
                `TMR_COM_OFF:    s_d.oc = s_q.oc;
                `TMR_COM_TOGGLE: s_d.oc = ~s_q.oc;
                `TMR_COM_CLEAR:  s_d.oc = 1'b0;
                `TMR_COM_SET:    s_d.oc = 1'b1;
            endcase
        end
        // Compare writes land in the buffer or straight in active
        if (compare_wr) begin
            s_d.ocr_buf = compare_wdata;
            if (!pwm) begin
                s_d.ocr = compare_wdata;
            end
        end
        // CPU write wins over any count; arms the match block
        if (count_wr) begin
            s_d.cnt = count_wdata;
            s_d.blk = 1'b1;
            s_d.match_seen = 1'b0;
        end
        // Clears lose to a same-cycle set, except an overflow clear of a flag already set
        if ((compare_flag_wr_one || compare_irq_ack)
            && !(timer_tick && match && !s_q.blk)) begin
            s_d.ocf = 1'b0;
        end
        if ((overflow_flag_wr_one || overflow_irq_ack)
            && !(s_d.tov && !s_q.tov)) begin
            s_d.tov = 1'b0;
        end
    end

    // All state held in one register; reset clears the output level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.cnt <= `TMR_CNT_RST;
            s_q.oc <= `TMR_OC_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // Outputs; compare readback shows the register the CPU targets
    assign count_value    = s_q.cnt;
    assign compare_value  = pwm ? s_q.ocr_buf : s_q.ocr;
    assign compare_flag   = s_q.ocf;
    assign overflow_flag  = s_q.tov;
    assign compare_output = s_q.oc;
    assign compare_irq    = s_q.ocf && compare_irq_enable
                            && global_irq_enable;
    assign overflow_irq   = s_q.tov && overflow_irq_enable
                            && global_irq_enable;
    // Port override while any output mode bit is set
    assign pin_out = (compare_output_mode != `TMR_COM_OFF)
                     ? s_q.oc : port_value;
    assign pin_oe  = output_pin_direction;

    a_flag_after_match: assert property (@(posedge clk) disable iff (!rst_n)
        ce && timer_tick && match && !s_q.blk |=> s_q.ocf)
        else $error("compare flag not set after match");

    a_ovf_set: assert property (@(posedge clk) disable iff (!rst_n)
        ce && timer_tick && !count_wr && waveform_mode == 2'h0 && at_top
        |=> s_q.tov)
        else $error("overflow flag not set at wrap");

    a_oc_off_hold: assert property (@(posedge clk) disable iff (!rst_n)
        ce && timer_tick && match && !s_q.blk && !force_compare_strobe
        && compare_output_mode == 2'h0 |=> $stable(s_q.oc))
        else $error("output moved with mode off");

    // No disable here: the check is about reset itself
    a_oc_reset: assert property (@(posedge clk)
        !rst_n |=> !s_q.oc)
        else $error("output register not cleared by reset");

    a_pin_port: assert property (@(posedge clk) disable iff (!rst_n)
        compare_output_mode == 2'h0 |-> pin_out == port_value)
        else $error("port value not passed through");

    a_pwm_load: assert property (@(posedge clk) disable iff (!rst_n)
        ce && timer_tick && pwm && at_top && !count_wr
        |=> s_q.ocr == $past(s_q.ocr_buf))
        else $error("buffered compare not loaded at top");

    a_irq_gating: assert property (@(posedge clk) disable iff (!rst_n)
        compare_irq == (s_q.ocf && compare_irq_enable && global_irq_enable))
        else $error("compare irq gating wrong");

    a_wr_priority: assert property (@(posedge clk) disable iff (!rst_n)
        ce && count_wr |=> s_q.cnt == $past(count_wdata))
        else $error("count write lost");

    a_stop_holds: assert property (@(posedge clk) disable iff (!rst_n)
        clock_select == 3'h0 && !count_wr ##1 !count_wr
        |=> $stable(s_q.cnt))
        else $error("counter moved while stopped");

    a_normal_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        ce && timer_tick && !count_wr && waveform_mode == 2'h0
        |=> s_q.cnt == $past(s_q.cnt) + 8'h01)
        else $error("normal mode did not increment");

    a_block_match: assert property (@(posedge clk) disable iff (!rst_n)
        ce && count_wr |=> !s_q.match_seen)
        else $error("match not blocked after write");

    a_force_noflag: assert property (@(posedge clk) disable iff (!rst_n)
        ce && force_compare_strobe && !timer_tick && !s_q.ocf
        |=> !s_q.ocf)
        else $error("force strobe set the flag");

    a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
        ce && compare_flag_wr_one && !timer_tick |=> !s_q.ocf)
        else $error("flag write one did not clear");

    a_pin_override: assert property (@(posedge clk) disable iff (!rst_n)
        compare_output_mode != 2'h0 |-> pin_out == s_q.oc)
        else $error("port not overridden");

    a_direct_ocr: assert property (@(posedge clk) disable iff (!rst_n)
        ce && compare_wr && !pwm ##1 !pwm
        |-> s_q.ocr == $past(compare_wdata))
        else $error("direct compare write lost");
endmodule
`default_nettype wire

// [tmr_cpu_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Interrupt-servicing side of the processor core
module tmr_cpu_model #(
    parameter int LATENCY = 3
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic service_en,
    input  wire logic compare_irq,
    input  wire logic overflow_irq,
    output logic      compare_irq_ack,
    output logic      overflow_irq_ack
);
    int wait_q;

    // Vector entry after a fixed latency, one pulse per request; with both pending only compare is acked
    always_ff @(posedge clk) begin
        compare_irq_ack  <= 1'b0;
        overflow_irq_ack <= 1'b0;
        if (!rst_n || !service_en || !(compare_irq || overflow_irq)) begin
            wait_q <= 0;
        end else if (wait_q == LATENCY) begin
            compare_irq_ack  <= compare_irq;
            overflow_irq_ack <= overflow_irq && !compare_irq;
            wait_q           <= wait_q + 1;
        end else if (wait_q < LATENCY) begin
            wait_q <= wait_q + 1;
        end
        // Above the latency: stall until no request is pending, no double service
    end
endmodule
`default_nettype wire

// [timer8_single_compare_core_test.sv]
`timescale 1ns/1ps
`default_nettype none
module timer8_single_compare_core_test;
    import tmr_pkg::*;
    logic      clk, rst_n, ce, count_wr, compare_wr, force_compare_strobe;
    logic      compare_flag_wr_one, overflow_flag_wr_one, compare_irq_enable;
    logic      overflow_irq_enable, global_irq_enable, compare_irq_ack;
    logic      overflow_irq_ack, port_value, output_pin_direction, service_en;
    logic      compare_flag, overflow_flag, compare_irq, overflow_irq;
    logic      compare_output, pin_out, pin_oe;
    logic [2:0] clock_select;
    logic [7:1] tick_sources;
    tmr_wgm_t  waveform_mode;
    tmr_com_t  compare_output_mode;
    tmr_byte_t count_wdata, compare_wdata, count_value, compare_value;
    int        bad_count, cmp_count, i;

    tmr_core i_dut (.clk, .rst_n, .ce, .clock_select, .tick_sources,
        .waveform_mode, .compare_output_mode, .count_wr, .count_wdata,
        .compare_wr, .compare_wdata, .force_compare_strobe,
        .compare_flag_wr_one, .overflow_flag_wr_one, .compare_irq_enable,
        .overflow_irq_enable, .global_irq_enable, .compare_irq_ack,
        .overflow_irq_ack, .port_value, .output_pin_direction, .count_value,
        .compare_value, .compare_flag, .overflow_flag, .compare_irq,
        .overflow_irq, .compare_output, .pin_out, .pin_oe);
    tmr_cpu_model #(.LATENCY(3)) i_cpu (.clk, .rst_n, .service_en,
        .compare_irq, .overflow_irq, .compare_irq_ack, .overflow_irq_ack);

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Sample one step after the edge so its updates have landed
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One prescaler pulse; select is registered, so count moves an edge later
    task automatic tick();
        @(posedge clk) tick_sources <= 7'h01;
        @(posedge clk) tick_sources <= 7'h00;
        step(2);
    endtask
    task automatic wr(bit cmp, tmr_byte_t v);
        @(posedge clk) begin
            count_wr      <= !cmp;
            compare_wr    <= cmp;
            count_wdata   <= v;
            compare_wdata <= v;
        end
        @(posedge clk) begin
            count_wr   <= 1'b0;
            compare_wr <= 1'b0;
        end
        step(1);
    endtask
    // 0 force strobe, 1 compare flag clear, 2 overflow flag clear
    task automatic pulse(int which);
        @(posedge clk) begin
            force_compare_strobe <= (which == 0);
            compare_flag_wr_one  <= (which == 1);
            overflow_flag_wr_one <= (which == 2);
        end
        @(posedge clk) begin
            force_compare_strobe <= 1'b0;
            compare_flag_wr_one  <= 1'b0;
            overflow_flag_wr_one <= 1'b0;
        end
        step(1);
    endtask
    task automatic t_count();
        wr(0, 8'h40);
        tick();
        check("stopped count", count_value, 8'h40);
        @(posedge clk) clock_select <= 3'h1;
        @(posedge clk) tick_sources <= 7'h01;
        @(posedge clk) begin
            tick_sources <= 7'h00;
            count_wr     <= 1'b1;
            count_wdata  <= 8'h10;
        end
        @(posedge clk) count_wr <= 1'b0;
        step(1);
        check("write over tick", count_value, 8'h10);
        wr(0, 8'hfe);
        tick();
        check("count max", count_value, 8'hff);
        check("ovf early", overflow_flag, 1'b0);
        tick();
        check("count wrap", count_value, 8'h00);
        check("ovf at zero", overflow_flag, 1'b1);
        @(posedge clk) {overflow_irq_enable, global_irq_enable} <= 2'h3;
        step(1);
        check("ovf irq", overflow_irq, 1'b1);
        pulse(2);
        check("ovf cleared", overflow_flag, 1'b0);
        @(posedge clk) {overflow_irq_enable, global_irq_enable} <= 2'h0;
    endtask
    task automatic t_match();
        wr(1, 8'h05);
        pulse(1);
        wr(0, 8'h03);
        tick();
        tick();
        check("match count", count_value, 8'h05);
        check("flag same tick", compare_flag, 1'b0);
        tick();
        check("flag next tick", compare_flag, 1'b1);
        step(3);
        check("flag held", compare_flag, 1'b1);
        pulse(1);
        check("flag cleared", compare_flag, 1'b0);
        wr(0, 8'h05);
        tick();
        tick();
        check("blocked running", compare_flag, 1'b0);
        @(posedge clk) clock_select <= 3'h0;
        wr(0, 8'h05);
        @(posedge clk) clock_select <= 3'h1;
        tick();
        tick();
        check("blocked stopped", compare_flag, 1'b0);
    endtask
    task automatic t_irq();
        wr(0, 8'h04);
        tick();
        tick();
        for (i = 0; i < 4; i++) begin
            @(posedge clk) {compare_irq_enable, global_irq_enable} <= 2'(i);
            step(1);
            check("irq gate", compare_irq, i == 3);
        end
        @(posedge clk) service_en <= 1'b1;
        for (i = 0; i < 20 && compare_flag !== 1'b0; i++) step(1);
        if (i == 20) begin
            bad_count++;
            finish_test();
        end
        check("flag serviced", compare_flag, 1'b0);
        @(posedge clk) {compare_irq_enable, global_irq_enable} <= 2'h0;
    endtask
    task automatic t_output();
        logic [1:0] com [5] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h0};
        logic       exp [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
        for (i = 0; i < 5; i++) begin
            @(posedge clk) compare_output_mode <= com[i];
            pulse(0);
            check("forced output", compare_output, exp[i]);
            check("force no flag", compare_flag, 1'b0);
            check("force no clear", count_value, 8'h06);
        end
        @(posedge clk) output_pin_direction <= 1'b1;
        step(1);
        check("pin port value", pin_out, 1'b0);
        check("pin direction", pin_oe, 1'b1);
        @(posedge clk) compare_output_mode <= 2'h1;
        step(1);
        check("pin override", pin_out, 1'b1);
        @(posedge clk) waveform_mode <= 2'h3;
        pulse(0);
        check("pwm force ignored", compare_output, 1'b1);
    endtask
    task automatic t_buffer();
        @(posedge clk) begin
            compare_output_mode <= 2'h0;
            waveform_mode       <= 2'h0;
        end
        wr(1, 8'h80);
        @(posedge clk) waveform_mode <= 2'h3;
        pulse(1);
        wr(1, 8'h22);
        check("buffer read", compare_value, 8'h22);
        wr(0, 8'h20);
        tick();
        tick();
        tick();
        check("buffer not live", compare_flag, 1'b0);
        wr(0, 8'hfe);
        tick();
        tick();
        wr(0, 8'h21);
        tick();
        tick();
        check("buffer at top", compare_flag, 1'b1);
    endtask

    // Reset, then the scenarios in order
    initial begin
        {rst_n, count_wr, compare_wr, force_compare_strobe} = 4'h0;
        {compare_flag_wr_one, overflow_flag_wr_one, compare_irq_enable} = 3'h0;
        {overflow_irq_enable, global_irq_enable, port_value} = 3'h0;
        {output_pin_direction, service_en} = 2'h0;
        ce                  = 1'b1;
        clock_select        = 3'h0;
        tick_sources        = 7'h00;
        waveform_mode       = 2'h0;
        compare_output_mode = 2'h0;
        count_wdata         = 8'h00;
        compare_wdata       = 8'h00;
        bad_count           = 0;
        cmp_count           = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        step(1);
        check("output at reset", compare_output, 1'b0);
        t_count();
        t_match();
        t_irq();
        t_output();
        t_buffer();
        finish_test();
    end
endmodule
`default_nettype wire
